/* File: ocd_map.svh */
// Register offsets, field positions, reset values and codes of the compare channel.
// Assumes inclusion by bare name from the package and the design.
`ifndef OCD_MAP_SVH
`define OCD_MAP_SVH
`define OCD_OFF_CTRL1 8'h00
`define OCD_OFF_CTRL2 8'h04
`define OCD_OFF_PRI 8'h08
`define OCD_OFF_SEC 8'h0C
`define OCD_OFF_TMR 8'h10
`define OCD_B_IDLE 13
`define OCD_B_TSEL_HI 12
`define OCD_B_TSEL_LO 10
`define OCD_B_FEN 7
`define OCD_B_FFLAG 4
`define OCD_B_TMODE 3
`define OCD_B_FMD 15
`define OCD_B_FOUT 14
`define OCD_B_FTRI 13
`define OCD_B_INV 12
`define OCD_B_TRIG 7
`define OCD_B_TSTAT 6
`define OCD_B_OTRIS 5
`define OCD_RST_CTRL1 16'h0000
`define OCD_RST_CTRL2 16'h000C
`define OCD_MASK_CTRL1 16'h3C8F
`define OCD_MASK_CTRL2 16'hF0BF
`define OCD_M_OFF 3'h0
`define OCD_M_SS_HI 3'h1
`define OCD_M_SS_LO 3'h2
`define OCD_M_TOG 3'h3
`define OCD_M_DSS 3'h4
`define OCD_M_DCP 3'h5
`define OCD_M_EPWM 3'h6
`define OCD_M_CPWM 3'h7
`define OCD_T_PER 3'h7
`define OCD_T_T1 3'h4
`define OCD_T_T3 3'h1
`define OCD_T_T2 3'h0
`define OCD_S_NONE 5'h00
`define OCD_S_IC1C 5'h05
`define OCD_S_T1 5'h0B
`define OCD_S_T2 5'h0C
`define OCD_S_T3 5'h0D
`define OCD_S_IC1I 5'h10
`define OCD_S_CMP1 5'h18
`define OCD_S_CMP2 5'h19
`define OCD_S_INT1 5'h1D
`define OCD_S_INT2 5'h1E
`define OCD_S_OWN 5'h1F
`define OCD_RESP_OKAY 2'h0
`define OCD_RESP_SLVERR 2'h2
`endif

/* File: ocd_pkg.sv */
// Types shared by the compare channel.
// Assumes ocd_map.svh is on the include path.
`include "ocd_map.svh"
package ocd_pkg;
    typedef logic [2:0] ocd_mode_t;
    typedef logic [15:0] ocd_reg_t;
endpackage : ocd_pkg

/* File: ocd_compare.sv */
// Output compare channel with dedicated timer and AXI4-Lite register slave.
// Assumes tick and event inputs come from logic on core_clk_in; fault and INT pins are async.
// Summary of operation
// R1: Pin changes on timer matches with compare values; each primary match, and each secondary match in modes 100, 101 and 111, pulses an event.
// R2: Idle-stop bit set halts the channel while the CPU idles.
// R3: Clock select: 111 peripheral, 100 Timer1, 001 Timer3, 000 Timer2, others none.
// R4: Fault input acts only while fault enable is set.
// R5: Fault flag set by hardware on a fault, read and written by software.
// R6: Trigger-clear mode clears trigger status on secondary match; else software only.
// R7: Centre PWM: high on primary match, low on secondary match.
// R8: Edge PWM: high when timer is zero, low on primary match.
// R9: Continuous pulse: start low, toggle on primary then secondary, repeatedly.
// R10: Double single-shot: start low, high on primary, low on secondary, once.
// R11: Toggle mode: pin toggles on every primary match.
// R12: Mode 010: start high, forced low on primary match.
// R13: Mode 001: start low, forced high on primary match.
// R14: Mode 000 disables the channel.
// R15: Compare values double-buffered only in PWM modes, else direct.
// R16: Fault lasts until source gone and new period; fault-mode bit also needs flag cleared.
// R17: In fault, pin tri-stated if fault tri-state set, else driven at fault level.
// R18: Invert bit inverts compare output before the pin.
// R19: Trigger/sync select: 1 triggers the timer, 0 synchronises it.
// R20: Trigger status set on trigger, timer runs; while clear, timer held at zero.
// R21: Output tri-state bit floats the pin, else the channel drives it.
// R22: Source defaults to Timer2; software must run Timer2 or choose another.
// R23: Source 01100 Timer2, 00000 none, 11111 own secondary match; comparators trigger only.
// R24: Sync mode: timer returns to zero on each source event, then counts.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`include "ocd_map.svh"
module ocd_compare
    import ocd_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int TIMER_W = 16
) (
    input wire logic core_clk_in, // 10 MHz clock
    input wire logic rst_in, // Async reset, active high
    input wire logic [ADDR_W-1:0] axi_awaddr_in, // Write address
    input wire logic axi_awvalid_in, // Write address valid
    output logic axi_awready_out, // Write address ready
    input wire logic [31:0] axi_wdata_in, // Write data
    input wire logic [3:0] axi_wstrb_in, // Write byte enables
    input wire logic axi_wvalid_in, // Write data valid
    output logic axi_wready_out, // Write data ready
    output logic [1:0] axi_bresp_out, // Write response
    output logic axi_bvalid_out, // Write response valid
    input wire logic axi_bready_in, // Write response ready
    input wire logic [ADDR_W-1:0] axi_araddr_in, // Read address
    input wire logic axi_arvalid_in, // Read address valid
    output logic axi_arready_out, // Read address ready
    output logic [31:0] axi_rdata_out, // Read data
    output logic [1:0] axi_rresp_out, // Read response
    output logic axi_rvalid_out, // Read data valid
    input wire logic axi_rready_in, // Read data ready
    input wire logic cpu_idle_in, // CPU in Idle mode
    input wire logic timer1_clock_in, // Timer1 count enable
    input wire logic timer2_clock_in, // Timer2 count enable
    input wire logic timer3_clock_in, // Timer3 count enable
    input wire logic timer1_event_in, // Timer1 period pulse
    input wire logic timer2_event_in, // Timer2 period pulse
    input wire logic timer3_event_in, // Timer3 period pulse
    input wire logic cmp1_event_in, // Comparator 1 pulse
    input wire logic cmp2_event_in, // Comparator 2 pulse
    input wire logic ic1_capture_in, // Input capture event pulse
    input wire logic ic1_irq_in, // Input capture interrupt pulse
    input wire logic int1_pin_in, // INT1 pin, async
    input wire logic int2_pin_in, // INT2 pin, async
    input wire logic fault_input_pin_in, // Fault A pin, active high, async
    output logic compare_output_pin_out, // Pin level
    output logic compare_output_pin_oe_n_out, // Pin enable, low drives
    output logic compare_event_out // One-cycle compare match pulse
);
    // Registers are 16 bits wide and the map needs five address bits
    if (TIMER_W != 16 || ADDR_W < 5) begin : g_bad_params
        $error("ocd_compare: TIMER_W must be 16 and ADDR_W at least 5");
    end

    function automatic ocd_reg_t ocd_merge(input ocd_reg_t old, input logic [31:0] wd,
                                           input logic [3:0] st);
        ocd_reg_t r;
        r = old;
        if (st[0]) r[7:0] = wd[7:0];
        if (st[1]) r[15:8] = wd[15:8];
        return r;
    endfunction : ocd_merge

    // =====================================================================
    // Registers and field decode
    logic [15:0] ctrl1, ctrl2, pri_buf, sec_buf, pri_act, sec_act, timer;
    logic fault_flag, trig_status, fault_active, cmp_out, done;
    ocd_mode_t mode_q;
    logic [2:0] sync_fault, sync_int1, sync_int2;

    wire idle_stop_bit = ctrl1[`OCD_B_IDLE];
    wire [2:0] timer_clock_select = ctrl1[`OCD_B_TSEL_HI:`OCD_B_TSEL_LO];
    wire fault_enable = ctrl1[`OCD_B_FEN];
    wire trigger_clear_mode = ctrl1[`OCD_B_TMODE];
    wire ocd_mode_t compare_mode = ctrl1[2:0];
    wire fault_mode_bit = ctrl2[`OCD_B_FMD];
    wire fault_level_bit = ctrl2[`OCD_B_FOUT];
    wire fault_tristate_bit = ctrl2[`OCD_B_FTRI];
    wire invert_bit = ctrl2[`OCD_B_INV];
    wire trigger_sync_select = ctrl2[`OCD_B_TRIG];
    wire output_tristate_bit = ctrl2[`OCD_B_OTRIS];
    wire [4:0] source_select_field = ctrl2[4:0];

    wire [15:0] c1_rd = ctrl1 | (16'(fault_flag) << `OCD_B_FFLAG);
    wire [15:0] c2_rd = ctrl2 | (16'(trig_status) << `OCD_B_TSTAT);

    // =====================================================================
    // AXI4-Lite slave: address and data taken together, one of each in flight
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    wire wr_go = axi_awvalid_in & axi_wvalid_in & ~bvalid;
    wire rd_go = axi_arvalid_in & ~rvalid;
    wire wr_c1 = wr_go & (axi_awaddr_in == ADDR_W'(`OCD_OFF_CTRL1));
    wire wr_c2 = wr_go & (axi_awaddr_in == ADDR_W'(`OCD_OFF_CTRL2));
    wire wr_pri = wr_go & (axi_awaddr_in == ADDR_W'(`OCD_OFF_PRI));
    wire wr_sec = wr_go & (axi_awaddr_in == ADDR_W'(`OCD_OFF_SEC));
    wire wr_ok = wr_c1 | wr_c2 | wr_pri | wr_sec;
    wire [15:0] c1_w = ocd_merge(c1_rd, axi_wdata_in, axi_wstrb_in);
    wire [15:0] c2_w = ocd_merge(c2_rd, axi_wdata_in, axi_wstrb_in);
    wire [15:0] pri_w = ocd_merge(pri_buf, axi_wdata_in, axi_wstrb_in);
    wire [15:0] sec_w = ocd_merge(sec_buf, axi_wdata_in, axi_wstrb_in);
    wire [ADDR_W-1:0] ra = axi_araddr_in;
    wire rd_ok = (ra == ADDR_W'(`OCD_OFF_CTRL1)) | (ra == ADDR_W'(`OCD_OFF_CTRL2)) |
                 (ra == ADDR_W'(`OCD_OFF_PRI)) | (ra == ADDR_W'(`OCD_OFF_SEC)) |
                 (ra == ADDR_W'(`OCD_OFF_TMR));
    wire [15:0] rd_mux = (ra == ADDR_W'(`OCD_OFF_CTRL1)) ? c1_rd :
                         (ra == ADDR_W'(`OCD_OFF_CTRL2)) ? c2_rd :
                         (ra == ADDR_W'(`OCD_OFF_PRI)) ? pri_buf :
                         (ra == ADDR_W'(`OCD_OFF_SEC)) ? sec_buf :
                         (ra == ADDR_W'(`OCD_OFF_TMR)) ? timer : 16'h0000;

    assign axi_awready_out = wr_go;
    assign axi_wready_out = wr_go;
    assign axi_arready_out = rd_go;
    assign axi_bvalid_out = bvalid;
    assign axi_bresp_out = bresp;
    assign axi_rvalid_out = rvalid;
    assign axi_rresp_out = rresp;
    assign axi_rdata_out = rdata;

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bvalid <= 1'b0;
            bresp <= `OCD_RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= `OCD_RESP_OKAY;
            rdata <= 32'h0000_0000;
        end else begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= wr_ok ? `OCD_RESP_OKAY : `OCD_RESP_SLVERR;
            end else if (axi_bready_in) begin
                bvalid <= 1'b0;
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rresp <= rd_ok ? `OCD_RESP_OKAY : `OCD_RESP_SLVERR;
                rdata <= {16'h0000, rd_mux};
            end else if (axi_rready_in) begin
                rvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Pin synchronisers; the third stage only feeds edge detection
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync_fault <= 3'h0;
            sync_int1 <= 3'h0;
            sync_int2 <= 3'h0;
        end else begin
            sync_fault <= {sync_fault[1:0], fault_input_pin_in};
            sync_int1 <= {sync_int1[1:0], int1_pin_in};
            sync_int2 <= {sync_int2[1:0], int2_pin_in};
        end
    end
    wire int1_edge = sync_int1[1] & ~sync_int1[2];
    wire int2_edge = sync_int2[1] & ~sync_int2[2];

    // =====================================================================
    // Timebase, source selection and matches
    wire enabled = compare_mode != `OCD_M_OFF; // [R14]
    wire halt = idle_stop_bit & cpu_idle_in; // [R2]
    wire run = enabled & ~halt;
    wire pwm = (compare_mode == `OCD_M_EPWM) | (compare_mode == `OCD_M_CPWM);
    wire clk_sel = (timer_clock_select == `OCD_T_PER) |
                   ((timer_clock_select == `OCD_T_T1) & timer1_clock_in) |
                   ((timer_clock_select == `OCD_T_T3) & timer3_clock_in) |
                   ((timer_clock_select == `OCD_T_T2) & timer2_clock_in); // [R3]
    wire trig_hold = trigger_sync_select & ~trig_status; // [R20]
    wire tick = run & clk_sel & ~trig_hold;
    wire match_pri = tick & (timer == pri_act);
    wire match_sec = tick & (timer == sec_act);
    wire match_zero = tick & (timer == 16'h0000);
    // Own secondary match may only synchronise; comparators may only trigger
    wire src_evt = ((source_select_field == `OCD_S_T1) & timer1_event_in) |
                   ((source_select_field == `OCD_S_T2) & timer2_event_in) |
                   ((source_select_field == `OCD_S_T3) & timer3_event_in) |
                   ((source_select_field == `OCD_S_IC1C) & ic1_capture_in) |
                   ((source_select_field == `OCD_S_IC1I) & ic1_irq_in) |
                   ((source_select_field == `OCD_S_INT1) & int1_edge) |
                   ((source_select_field == `OCD_S_INT2) & int2_edge) |
                   (trigger_sync_select & (source_select_field == `OCD_S_CMP1) & cmp1_event_in) |
                   (trigger_sync_select & (source_select_field == `OCD_S_CMP2) & cmp2_event_in) |
                   (~trigger_sync_select & (source_select_field == `OCD_S_OWN) & match_sec); // [R23]
    wire sync_hit = run & ~trigger_sync_select & src_evt; // [R19]
    wire trig_set = run & trigger_sync_select & src_evt; // [R19]
    wire trig_clr = trigger_clear_mode & match_sec; // [R6]
    wire [15:0] next_timer = ~enabled ? 16'h0000 :
                             halt ? timer :
                             (trig_hold | sync_hit) ? 16'h0000 : // [R20] [R24]
                             tick ? timer + 16'h0001 : timer;
    wire new_period = run & (sync_hit | (tick & (timer == 16'hFFFF)));
    wire fault_hit = fault_enable & sync_fault[1]; // [R4]
    wire fault_end = new_period & ~fault_hit & (~fault_mode_bit | ~fault_flag); // [R16]

    // =====================================================================
    // Compare output sequencing
    logic next_cmp_out, next_done;
    always_comb begin
        next_cmp_out = cmp_out;
        next_done = done;
        if (compare_mode != mode_q) begin
            next_cmp_out = (compare_mode == `OCD_M_SS_LO); // [R12]
            next_done = 1'b0;
        end else if (run) begin
            unique case (compare_mode)
                `OCD_M_OFF: next_cmp_out = 1'b0; // [R14]
                `OCD_M_SS_HI: if (match_pri) next_cmp_out = 1'b1; // [R13]
                `OCD_M_SS_LO: if (match_pri) next_cmp_out = 1'b0; // [R12]
                `OCD_M_TOG: if (match_pri) next_cmp_out = ~cmp_out; // [R11]
                `OCD_M_DSS: begin
                    if (match_pri & ~done) next_cmp_out = 1'b1; // [R10]
                    if (match_sec & cmp_out & ~done) begin
                        next_cmp_out = 1'b0;
                        next_done = 1'b1;
                    end
                end
                `OCD_M_DCP: begin
                    if (match_pri) next_cmp_out = 1'b1; // [R9]
                    if (match_sec & cmp_out) next_cmp_out = 1'b0;
                end
                `OCD_M_EPWM: begin
                    if (match_zero) next_cmp_out = 1'b1; // [R8]
                    if (match_pri) next_cmp_out = 1'b0;
                end
                `OCD_M_CPWM: begin
                    if (match_pri) next_cmp_out = 1'b1; // [R7]
                    if (match_sec) next_cmp_out = 1'b0;
                end
            endcase
        end
    end
    wire uses_sec = (compare_mode == `OCD_M_DSS) | (compare_mode == `OCD_M_DCP) |
                    (compare_mode == `OCD_M_CPWM);
    wire next_event = run & (match_pri | (uses_sec & match_sec)); // [R1]
    // Fault level bypasses inversion: the safe state is absolute
    wire next_pin = fault_active ? fault_level_bit : (cmp_out ^ invert_bit); // [R17] [R18]
    wire next_oe_n = output_tristate_bit | (fault_active & fault_tristate_bit); // [R21] [R17]

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ctrl1 <= `OCD_RST_CTRL1;
            ctrl2 <= `OCD_RST_CTRL2; // [R22]
            pri_buf <= 16'h0000;
            sec_buf <= 16'h0000;
            pri_act <= 16'h0000;
            sec_act <= 16'h0000;
            timer <= 16'h0000;
            fault_flag <= 1'b0;
            trig_status <= 1'b0;
            fault_active <= 1'b0;
            cmp_out <= 1'b0;
            done <= 1'b0;
            mode_q <= `OCD_M_OFF;
            compare_output_pin_out <= 1'b0;
            compare_output_pin_oe_n_out <= 1'b1;
            compare_event_out <= 1'b0;
        end else begin
            if (wr_c1) ctrl1 <= c1_w & `OCD_MASK_CTRL1;
            if (wr_c2) ctrl2 <= c2_w & `OCD_MASK_CTRL2;
            if (wr_pri) pri_buf <= pri_w;
            if (wr_sec) sec_buf <= sec_w;
            if (~pwm | new_period | ~enabled) begin
                pri_act <= pri_buf; // [R15]
                sec_act <= sec_buf;
            end
            timer <= next_timer;
            fault_flag <= fault_hit | (wr_c1 ? c1_w[`OCD_B_FFLAG] : fault_flag); // [R5]
            trig_status <= trig_set | (wr_c2 ? c2_w[`OCD_B_TSTAT] :
                                       (trig_clr ? 1'b0 : trig_status)); // [R6] [R20]
            fault_active <= fault_hit | (fault_active & ~fault_end); // [R16]
            cmp_out <= next_cmp_out;
            done <= next_done;
            mode_q <= compare_mode;
            compare_output_pin_out <= next_pin;
            compare_output_pin_oe_n_out <= next_oe_n;
            compare_event_out <= next_event;
        end
    end

    // =====================================================================
    // Checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_shot_done;
        compare_mode == `OCD_M_DSS && mode_q == `OCD_M_DSS && done;
    endsequence

    a_idle_halt_hold: assert property (halt && enabled |=> $stable(timer)) // [R2]
        else $error("timer moved while halted in idle");
    a_fault_flag_set: assert property (fault_enable && sync_fault[1] |=> fault_flag) // [R5]
        else $error("fault flag not set on fault");
    a_fault_gated: assert property (!fault_enable && !fault_active |=> !fault_active) // [R4]
        else $error("fault entered while fault input disabled");
    a_trig_hold_clear: assert property
        (trigger_sync_select && !trig_status && enabled && !halt |=> timer == 16'h0000) // [R20]
        else $error("timer not held clear before trigger");
    a_trig_auto_clear: assert property
        (trig_clr && !trig_set && !wr_c2 |=> !trig_status) // [R6]
        else $error("trigger status not cleared on secondary match");
    a_edge_pwm_rise: assert property (mode_q == `OCD_M_EPWM && compare_mode == mode_q &&
        match_zero && pri_act != 16'h0000 |=> cmp_out) // [R8]
        else $error("edge pwm did not rise at zero");
    a_centre_fall: assert property (mode_q == `OCD_M_CPWM && compare_mode == mode_q &&
        match_sec |=> !cmp_out) // [R7]
        else $error("centre pwm did not fall on secondary match");
    a_toggle_match: assert property (mode_q == `OCD_M_TOG && compare_mode == mode_q &&
        match_pri |=> cmp_out != $past(cmp_out)) // [R11]
        else $error("toggle mode missed a toggle");
    a_single_shot_once: assert property (s_shot_done |=> !cmp_out && done) // [R10]
        else $error("single shot pulsed again");
    a_fault_pin_level: assert property (fault_active && !fault_tristate_bit &&
        !output_tristate_bit |=> compare_output_pin_out == $past(fault_level_bit)
        && !compare_output_pin_oe_n_out) // [R17]
        else $error("pin not at fault level");
    a_pin_tristate: assert property (output_tristate_bit |=> compare_output_pin_oe_n_out) // [R21]
        else $error("pin driven while tri-stated");
    a_event_pulse: assert property (run && match_pri |=> compare_event_out) // [R1]
        else $error("no event on primary match");
endmodule : ocd_compare

/* File: ocd_load.sv */
// External load on the compare output pin.
// Assumes a pin level and a drive enable that is low while the channel drives.
module ocd_load (
    input wire logic clk_in, // Core clock
    input wire logic pin_in, // Level driven by the channel
    input wire logic oe_n_in, // Low while the channel drives
    output logic level_out // Level seen by the load
);
    timeunit 1ns;
    timeprecision 1ns;
    logic last = 1'b0;
    always @(posedge clk_in) begin
        if (!oe_n_in) begin
            last <= pin_in;
        end
    end
    // No pull on the net: a floating pin must not look like a held level
    assign level_out = oe_n_in ? ~last : pin_in;
endmodule : ocd_load

/* File: output_compare_dedicated_timer_tb_top.sv */
// Self-checking bench of the compare channel: bus, modes, fault, clocks, idle.
// Assumes ocd_map.svh, ocd_pkg, ocd_compare and ocd_load are compiled first.
`include "ocd_map.svh"
module output_compare_dedicated_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] C1 = `OCD_OFF_CTRL1;
    localparam logic [7:0] C2 = `OCD_OFF_CTRL2;
    localparam logic [7:0] PR = `OCD_OFF_PRI;
    localparam logic [7:0] SC = `OCD_OFF_SEC;
    localparam logic [7:0] TM = `OCD_OFF_TMR;
    // Pin before primary, after primary, after secondary
    localparam logic [2:0] TBL [8] = '{3'h0, 3'h3, 3'h4, 3'h3, 3'h2, 3'h2, 3'h4, 3'h2};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, noise = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'h0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic fault = 1'b0, idle = 1'b0, t2ev = 1'b0;
    logic [2:0] tclk = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, pin, oe_n, ev, level;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, a, b;
    int err_count = 0, compares = 0, cycles = 0, seed = 42730, evs = 0;
    ocd_compare i_dut (
        .core_clk_in(clk), .rst_in(rst),
        .axi_awaddr_in(awaddr), .axi_awvalid_in(awv), .axi_awready_out(awready),
        .axi_wdata_in(wdata), .axi_wstrb_in(wstrb), .axi_wvalid_in(wv),
        .axi_wready_out(wready), .axi_bresp_out(bresp), .axi_bvalid_out(bvalid),
        .axi_bready_in(bready), .axi_araddr_in(araddr), .axi_arvalid_in(arv),
        .axi_arready_out(arready), .axi_rdata_out(rdata), .axi_rresp_out(rresp),
        .axi_rvalid_out(rvalid), .axi_rready_in(rready), .cpu_idle_in(idle),
        .timer1_clock_in(tclk[0]), .timer2_clock_in(tclk[1]), .timer3_clock_in(tclk[2]),
        .timer1_event_in(noise[0]), .timer2_event_in(t2ev), .timer3_event_in(noise[1]),
        .cmp1_event_in(noise[2]), .cmp2_event_in(noise[3]), .ic1_capture_in(noise[4]),
        .ic1_irq_in(noise[5]), .int1_pin_in(noise[6]), .int2_pin_in(noise[7]),
        .fault_input_pin_in(fault), .compare_output_pin_out(pin),
        .compare_output_pin_oe_n_out(oe_n), .compare_event_out(ev)
    );
    ocd_load i_load (.clk_in(clk), .pin_in(pin), .oe_n_in(oe_n), .level_out(level));
    always #50 clk = ~clk;
    // Unselected sources chatter; they must never move the channel
    always @(posedge clk) noise <= 8'($random(seed));
    // Match events counted where the pulse has settled
    always @(negedge clk) if (ev === 1'b1) evs++;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end
    // =========================================
    // Bus and check tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic wrx(input logic [7:0] ad, input logic [15:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        @(posedge clk);
        awaddr <= ad;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do @(negedge clk); while (awready !== 1'b1);
        @(posedge clk);
        awv <= 1'b0;
        wv <= 1'b0;
        do @(negedge clk); while (bvalid !== 1'b1);
        chk("bresp", 32'(er), 32'(bresp));
        @(posedge clk);
        bready <= 1'b0;
    endtask : wrx
    task automatic wr(input logic [7:0] ad, input logic [15:0] d);
        wrx(ad, d, 4'hF, 2'h0);
    endtask : wr
    task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
        @(posedge clk);
        araddr <= ad;
        arv <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arv <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        d = rdata;
        rs = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask : rd
    task automatic rdchk(input logic [7:0] ad, input logic [15:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] rs;
        rd(ad, d, rs);
        chk("rdata", {16'h0000, e}, d);
        chk("rresp", 32'(er), 32'(rs));
    endtask : rdchk
    function automatic logic [2:0] exp_pin(input logic [2:0] m, input logic inv);
        return TBL[m] ^ {3{inv}};
    endfunction : exp_pin
    // Trigger mode on Timer2 holds the timer at zero until one event starts it
    task automatic run(input logic [2:0] m, input logic inv, input logic t);
        logic [15:0] p, c2;
        logic [2:0] e;
        int e0;
        p = 16'(8 + {$random(seed)} % 64);
        c2 = 16'h008C | {3'h0, inv, 12'h000};
        e = exp_pin(m, inv);
        wr(C1, 16'h0000);
        wr(C2, c2);
        wr(PR, p);
        wr(SC, p + 16'd12);
        wr(C1, 16'h1C00 | {12'h000, t, m});
        e0 = evs;
        @(posedge clk);
        t2ev <= 1'b1;
        @(posedge clk);
        t2ev <= 1'b0;
        repeat (p - 2) @(negedge clk);
        chk("pin", 32'(e[2]), 32'(level));
        repeat (8) @(negedge clk);
        chk("pin", 32'(e[1]), 32'(level));
        repeat (12) @(negedge clk);
        chk("pin", 32'(e[0]), 32'(level));
        chk("oe_n", 32'h0, 32'(oe_n));
        chk("events", (m == 3'h0) ? 0 : (m[2] && m != 3'h6) ? 2 : 1, 32'(evs - e0));
        // A disabled channel takes no trigger
        rdchk(C2, c2 | ((t || m == 3'h0) ? 16'h0000 : 16'h0040), 2'h0);
    endtask : run
    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    // =========================================
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdchk(C1, 16'h0000, 2'h0);
        rdchk(C2, 16'h000C, 2'h0);
        rdchk(8'h14, 16'h0000, 2'h2);
        wrx(8'h14, 16'hFFFF, 4'hF, 2'h2);
        wrx(PR, 16'h1234, 4'hF, 2'h0);
        wrx(PR, 16'hABCD, 4'h2, 2'h0);
        rdchk(PR, 16'hAB34, 2'h0);
        for (int m = 0; m < 8; m++) begin
            run(3'(m), (m != 0) & 1'($random(seed)), 1'b0);
        end
        run(3'h1, 1'b0, 1'b1);
        rdchk(TM, 16'h0000, 2'h0);
        run(3'h3, 1'b0, 1'b0);
        for (int k = 0; k < 4; k++) begin
            wr(C1, k == 0 ? 16'h0003 : k == 1 ? 16'h0403 : k == 2 ? 16'h1003 : 16'h3C03);
            tclk <= k == 0 ? 3'h5 : k == 1 ? 3'h3 : k == 2 ? 3'h6 : 3'h7;
            idle <= (k == 3);
            rd(TM, a, r);
            rd(TM, b, r);
            chk("timer_frozen", a, b);
            tclk <= 3'h7;
            idle <= 1'b0;
            rd(TM, a, r);
            chk("timer_runs", 32'h1, 32'(a !== b));
        end
        wr(C1, 16'h0000);
        wr(C2, 16'h008C);
        wr(PR, 16'h0010);
        wr(C1, 16'h1C02);
        fault <= 1'b1;
        repeat (8) @(negedge clk);
        chk("pin", 32'h1, 32'(level));
        wr(C1, 16'h1C82);
        repeat (6) @(negedge clk);
        chk("pin", 32'h0, 32'(level));
        rdchk(C1, 16'h1C92, 2'h0);
        wr(C2, 16'h608C);
        repeat (3) @(negedge clk);
        chk("oe_n", 32'h1, 32'(oe_n));
        wr(C2, 16'h408C);
        repeat (3) @(negedge clk);
        chk("pin", 32'h1, 32'(level));
        fault <= 1'b0;
        wr(C1, 16'h0000);
        wr(C2, 16'h00AC);
        repeat (3) @(negedge clk);
        chk("oe_n", 32'h1, 32'(oe_n));
        final_report();
    end
endmodule : output_compare_dedicated_timer_tb_top
